// ===== test/optcfg_assertions.sv
// Purpose: port checks for the option loader
// Assumes: one clock, async low reset
// Notes:   bound to the top module
`timescale 1ns/1ns
`default_nettype none
module optcfg_chk (
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  input wire logic                  opt_rd_out,
  input wire optcfg_pkg::opt_addr_t opt_addr_out,
  input wire logic                  standby_in,
  input wire logic                  cpu_reset_hold_out,
  input wire logic                  wdog_count_in_standby_out,
  input wire logic                  wdog_run_after_reset_out,
  input wire logic                  wdog_interval_irq_en_out,
  input wire logic                  wdog_interval_irq_out,
  input wire logic                  wdog_overflow_out,
  input wire logic [1:0]            vdet_mode_out,
  input wire logic                  vdet_int_rst_mode_out,
  input wire logic                  vdet_rst_only_mode_out,
  input wire logic [2:0]            vdet_coarse_code_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  fetch_order_a: assert property (opt_rd_out && opt_addr_out == 20'h0_00C0 |=> opt_rd_out &&
    opt_addr_out == 20'h0_00C1 ##1 opt_rd_out && opt_addr_out == 20'h0_00C2 ##1 opt_rd_out && opt_addr_out == 20'h0_00C3)
    else $error("fetch order wrong");
  load_bound_a: assert property (cpu_reset_hold_out |-> ##[1:20] !cpu_reset_hold_out) else $error("load slow");
  no_refetch_a: assert property (!cpu_reset_hold_out |=> !cpu_reset_hold_out && !opt_rd_out)
    else $error("fetch after load");
  fields_hold_a: assert property (!cpu_reset_hold_out && !$past(cpu_reset_hold_out, 2) |-> $stable({vdet_mode_out,
    vdet_coarse_code_out, wdog_run_after_reset_out, wdog_interval_irq_en_out, wdog_count_in_standby_out}))
    else $error("field moved");
  mode_decode_a: assert property (!cpu_reset_hold_out && !$past(cpu_reset_hold_out, 2) |->
    vdet_int_rst_mode_out == (vdet_mode_out == 2'b10) && vdet_rst_only_mode_out == (vdet_mode_out == 2'b11))
    else $error("mode flags wrong");
  dog_stopped_a: assert property (!wdog_run_after_reset_out |-> !wdog_overflow_out && !wdog_interval_irq_out)
    else $error("stopped dog fired");
  irq_off_a: assert property (!wdog_interval_irq_en_out |-> !wdog_interval_irq_out) else $error("irq while off");
  standby_halt_a: assert property ((standby_in && !wdog_count_in_standby_out)[*2] |-> !wdog_overflow_out)
    else $error("counted in standby");
  cover property (wdog_overflow_out && standby_in);
  cover property (wdog_interval_irq_out);
  cover property (vdet_rst_only_mode_out);
endmodule : optcfg_chk
bind option_byte_config_decode optcfg_chk chk (.mclk_in, .rst_n_in, .opt_rd_out, .opt_addr_out, .standby_in,
  .cpu_reset_hold_out, .wdog_count_in_standby_out, .wdog_run_after_reset_out, .wdog_interval_irq_en_out,
  .wdog_interval_irq_out, .wdog_overflow_out, .vdet_mode_out, .vdet_int_rst_mode_out, .vdet_rst_only_mode_out,
  .vdet_coarse_code_out);
`default_nettype wire

// ===== test/option_byte_config_decode_tb_top.sv
// Purpose: loads option images and measures the watchdog
// Assumes: slow tick every cycle while measuring
// Notes:   each image is {C3, C2, C1, C0}
`timescale 1ns/1ns
`default_nettype none
module option_byte_config_decode_tb_top;
  import optcfg_pkg::*;
  logic mclk_in = 0, rst_n_in = 0, slow_osc_tick_in = 0, standby_in = 0, wdog_refresh_in = 0, opt_rd_out;
  logic cpu_reset_hold_out, wdog_count_in_standby_out, wdog_run_after_reset_out, wdog_interval_irq_en_out;
  logic wdog_interval_irq_out, wdog_overflow_out, wdog_window_open_out, reset_pin_function_sel_out;
  logic vdet_int_rst_mode_out, vdet_rst_only_mode_out;
  logic [1:0] wdog_open_period_out, vdet_fine_code_out, vdet_mode_out, flash_mode_out;
  logic [2:0] wdog_period_sel_out, vdet_coarse_code_out;
  logic [3:0] fast_osc_freq_sel_out;
  opt_addr_t opt_addr_out;
  opt_byte_t opt_data_in, debug_opt_out;
  logic [31:0] image = 32'h0000_0000;
  int mismatches = 0, n_tests = 0;
  int exps [8] = '{6, 7, 8, 9, 11, 13, 14, 16};
  // window codes never 00, level codes only from the listed pairs
  logic [31:0] imgs [8] = '{32'h85E0_7FB0, 32'h84A9_3A53, 32'h04E1_4634, 32'h85EA_72F6,
                            32'h85AB_2FB8, 32'h85ED_FD3A, 32'h85E0_7F5C, 32'h85E0_7FE0};
  always #2 mclk_in = ~mclk_in;
  option_byte_config_decode dut (.mclk_in, .rst_n_in, .opt_rd_out, .opt_addr_out, .opt_data_in, .slow_osc_tick_in,
    .standby_in, .wdog_refresh_in, .cpu_reset_hold_out, .wdog_count_in_standby_out, .wdog_period_sel_out,
    .wdog_run_after_reset_out, .wdog_open_period_out, .wdog_interval_irq_en_out, .wdog_interval_irq_out,
    .wdog_overflow_out, .wdog_window_open_out, .vdet_coarse_code_out, .reset_pin_function_sel_out,
    .vdet_fine_code_out, .vdet_mode_out, .vdet_int_rst_mode_out, .vdet_rst_only_mode_out, .flash_mode_out,
    .fast_osc_freq_sel_out, .debug_opt_out);
  optstore_model store (.mclk_in, .rst_n_in, .opt_rd_in(opt_rd_out), .opt_addr_in(opt_addr_out), .image_in(image),
    .opt_data_out(opt_data_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic load(input logic [31:0] img);
    int i;
    image = img;
    @(posedge mclk_in) rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 40 && cpu_reset_hold_out !== 1'b0; i++) @(negedge mclk_in);
    if (i == 40) begin
      mismatches++;
      complete_run();
    end
    repeat (2) @(negedge mclk_in);
    check({wdog_interval_irq_en_out, wdog_open_period_out, wdog_run_after_reset_out, wdog_period_sel_out,
      wdog_count_in_standby_out}, img[7:0]);
    check({vdet_coarse_code_out, reset_pin_function_sel_out, vdet_fine_code_out, vdet_mode_out}, img[15:8]);
    check({vdet_int_rst_mode_out, vdet_rst_only_mode_out}, {img[9:8] == 2'b10, img[9:8] == 2'b11});
    check({flash_mode_out, fast_osc_freq_sel_out, debug_opt_out}, {img[23:22], img[19:16], img[31:24]});
  endtask : load
  task automatic quiet(input logic sb, input logic rf);
    int n;
    n = 0;
    @(posedge mclk_in);
    standby_in <= sb;
    wdog_refresh_in <= rf;
    slow_osc_tick_in <= 1'b1;
    repeat (300) begin
      @(negedge mclk_in);
      n += (wdog_overflow_out === 1'b1) + (wdog_interval_irq_out === 1'b1);
    end
    check(n, 0);
  endtask : quiet
  task automatic measure(input logic [7:0] c0);
    int i, p, nw, ni, no;
    p = 1 << exps[c0[3:1]];
    @(posedge mclk_in);
    standby_in <= c0[0];
    wdog_refresh_in <= 1'b0;
    slow_osc_tick_in <= 1'b1;
    @(negedge mclk_in);
    for (i = 0; i <= p + 40 && wdog_overflow_out !== 1'b1; i++) @(negedge mclk_in);
    if (i > p + 40) begin
      mismatches++;
      complete_run();
    end
    nw = 0;
    ni = 0;
    no = 0;
    repeat (p) begin
      nw += (wdog_window_open_out === 1'b1);
      ni += (wdog_interval_irq_out === 1'b1);
      no += (wdog_overflow_out === 1'b1);
      @(negedge mclk_in);
    end
    check({no[30:0], wdog_overflow_out}, {31'd1, 1'b1});
    check(ni, c0[7]);
    check(nw, c0[6:5] == 2'b11 ? p : (c0[6:5] == 2'b01 ? p / 2 : p - p / 4));
  endtask : measure
  initial begin
    for (int k = 0; k < 8; k++) begin
      load(imgs[k]);
      if (imgs[k][4]) measure(imgs[k][7:0]);
      else quiet(1'b0, 1'b0);
      if (k == 0) begin
        quiet(1'b1, 1'b0);
        quiet(1'b0, 1'b1);
      end
      $display("test %0d done", k);
    end
    complete_run();
  end
endmodule : option_byte_config_decode_tb_top
`default_nettype wire

// ===== test/optstore_model.sv
// Purpose: option storage model, answers two cycles after a strobe
// Assumes: four option bytes from C0 to C3, image[7:0] is C0
// Notes:   the bus shows a toggling pattern when not answering
`timescale 1ns/1ns
`default_nettype none
module optstore_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        opt_rd_in,
  input  wire logic [19:0] opt_addr_in,
  input  wire logic [31:0] image_in,
  output logic      [7:0]  opt_data_out
);
  logic [1:0] v_r;
  logic [7:0] d1_r, d2_r, last_r;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      v_r    <= 2'b00;
      d1_r   <= 8'h00;
      d2_r   <= 8'h00;
      last_r <= 8'h00;
    end else begin
      v_r    <= {v_r[0], opt_rd_in};
      d1_r   <= (opt_addr_in[19:2] == 18'h0_0030) ? image_in[{opt_addr_in[1:0], 3'b000} +: 8] : 8'hA5;
      d2_r   <= d1_r;
      last_r <= opt_data_out;
    end
  end
  assign opt_data_out = v_r[1] ? d2_r : ~last_r;
endmodule : optstore_model
`default_nettype wire

// ===== verilog/optcfg_cfg.svh
// Purpose: constants for the option byte loader and decoder
// Assumes: byte-wide option storage read port with fixed read latency
// Notes:   timing counts are in mclk_in cycles at 250 MHz
// Functional notes
// - fetch option bytes automatically after every reset release, before cpu runs
// - no runtime write path; values change only through the reset fetch
// - three user bytes at 0xC0..0xC2, debug byte at 0xC3
// - byte 0xC0 decodes into watchdog control, applied at reset release
// - bit 0: 0 halts watchdog in standby, 1 keeps counting
// - bits 3:1 pick overflow 2^6,7,8,9,11,13,14,16 slow osc cycles
// - bit 4: 1 starts watchdog after reset sequence, 0 keeps it stopped
// - bits 6:5 window open 50/75/100 percent; 00 never programmed
// - bit 7 raises interval irq at 75 percent plus half slow cycle; the timebase fires it on the tick at 75 percent plus one slow cycle
// - byte 0xC1: coarse 7:5, reset pin 4, fine 3:2, mode 1:0
// - mode 10: interrupt and reset, coarse low level, fine high level
// - mode 11: reset only, coarse and fine jointly pick one level pair
// - byte 0xC2 decodes oscillator frequency and flash mode fields
`ifndef OPTCFG_CFG_SVH
`define OPTCFG_CFG_SVH
`define OPT_ADDR_WDOG     20'h0_00C0
`define OPT_ADDR_VDET     20'h0_00C1
`define OPT_ADDR_OSC      20'h0_00C2
`define OPT_ADDR_DEBUG    20'h0_00C3
`define OPT_NUM_BYTES     3'd4
`define OPT_RD_LAT        2'd2
`define WD_STBY_BIT       0
`define WD_PSEL_HI        3
`define WD_PSEL_LO        1
`define WD_RUN_BIT        4
`define WD_WIN_HI         6
`define WD_WIN_LO         5
`define WD_IRQ_BIT        7
`define VD_COARSE_HI      7
`define VD_COARSE_LO      5
`define VD_PIN_BIT        4
`define VD_FINE_HI        3
`define VD_FINE_LO        2
`define VD_MODE_HI        1
`define VD_MODE_LO        0
`define OSC_FLASH_HI      7
`define OSC_FLASH_LO      6
`define OSC_FREQ_HI       3
`define OSC_FREQ_LO       0
`define VD_MODE_INT_RST   2'b10
`define VD_MODE_RST       2'b11
`define WD_WIN_PROHIB     2'b00
`endif

// ===== verilog/optcfg_pkg.sv
// Purpose: types for the option byte loader
// Assumes: nothing
// Notes:   constants live in optcfg_cfg.svh
package optcfg_pkg;
  typedef enum logic [1:0] {
    LD_IDLE,
    LD_FETCH,
    LD_DONE
  } load_state_e;
  typedef logic [7:0]  opt_byte_t;
  typedef logic [19:0] opt_addr_t;
  typedef logic [16:0] wd_count_t;
endpackage : optcfg_pkg

// ===== verilog/option_byte_config_decode.sv
// Purpose: reset-time option byte fetch, decode and watchdog timebase
// Assumes: storage returns data OPT_RD_LAT cycles after a read strobe
// Notes:   slow osc arrives as a synchronous one-cycle tick input
`include "optcfg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module option_byte_config_decode (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  output logic                       opt_rd_out,
  output optcfg_pkg::opt_addr_t      opt_addr_out,
  input  wire optcfg_pkg::opt_byte_t opt_data_in,
  input  wire logic                  slow_osc_tick_in,
  input  wire logic                  standby_in,
  input  wire logic                  wdog_refresh_in,
  output logic                       cpu_reset_hold_out,
  output logic                       wdog_count_in_standby_out,
  output logic [2:0]                 wdog_period_sel_out,
  output logic                       wdog_run_after_reset_out,
  output logic [1:0]                 wdog_open_period_out,
  output logic                       wdog_interval_irq_en_out,
  output logic                       wdog_interval_irq_out,
  output logic                       wdog_overflow_out,
  output logic                       wdog_window_open_out,
  output logic [2:0]                 vdet_coarse_code_out,
  output logic                       reset_pin_function_sel_out,
  output logic [1:0]                 vdet_fine_code_out,
  output logic [1:0]                 vdet_mode_out,
  output logic                       vdet_int_rst_mode_out,
  output logic                       vdet_rst_only_mode_out,
  output logic [1:0]                 flash_mode_out,
  output logic [3:0]                 fast_osc_freq_sel_out,
  output optcfg_pkg::opt_byte_t      debug_opt_out
);
  import optcfg_pkg::*;

  // overflow period in slow osc cycles, as 2^n
  function automatic wd_count_t period_of(input logic [2:0] sel);
    logic [4:0] e;
    e = 5'd6;
    unique case (sel)
      3'd0: e = 5'd6;
      3'd1: e = 5'd7;
      3'd2: e = 5'd8;
      3'd3: e = 5'd9;
      3'd4: e = 5'd11;
      3'd5: e = 5'd13;
      3'd6: e = 5'd14;
      3'd7: e = 5'd16;
    endcase
    period_of = wd_count_t'(17'd1 << e);
  endfunction : period_of

  // three quarters of the period, in half slow cycles
  function automatic logic [17:0] three_half_of(input wd_count_t p);
    three_half_of = 18'(({1'b0, p} * 18'd3) >> 1);
  endfunction : three_half_of

  // window start in half slow cycles; 00 is never programmed and reads as open
  function automatic logic [17:0] win_start_of(input logic [1:0] code, input wd_count_t p);
    win_start_of = 18'd0;
    unique case (code)
      2'b00: win_start_of = 18'd0;
      2'b01: win_start_of = {1'b0, p};
      2'b10: win_start_of = {2'b00, p[16:1]};
      2'b11: win_start_of = 18'd0;
    endcase
  endfunction : win_start_of

  ////////////////////////////////////////////////////////////////////////
  // loader
  load_state_e state_r, state_nxt;
  logic [2:0]  issue_r;
  logic [2:0]  recv_r;
  logic [3:0]  pend_r;
  opt_byte_t   bytes_r [0:3];

  wire issue_go  = (state_r == LD_FETCH) && (issue_r != `OPT_NUM_BYTES);
  wire data_ok   = pend_r[0];
  wire all_recv  = (recv_r == `OPT_NUM_BYTES);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LD_IDLE:  state_nxt = LD_FETCH;
      LD_FETCH: if (all_recv) state_nxt = LD_DONE;
      LD_DONE:  state_nxt = LD_DONE;
      default:  state_nxt = LD_IDLE;
    endcase
  end

  // read delay line: bit k set means data due in k cycles
  // the strobe leaves one cycle after issue_go, in step with pend_r, so the due slot sits at OPT_RD_LAT
  wire [3:0] pend_nxt = {1'b0, pend_r[3:1]} | (issue_go ? (4'b0001 << `OPT_RD_LAT) : 4'b0000);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= LD_IDLE;
      issue_r <= 3'd0;
      recv_r  <= 3'd0;
      pend_r  <= 4'b0000;
    end else begin
      state_r <= state_nxt;
      pend_r  <= pend_nxt;
      if (issue_go) issue_r <= issue_r + 3'd1;
      if (data_ok)  recv_r  <= recv_r + 3'd1;
    end
  end

  // capture only during fetch; no other write path exists
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) bytes_r[i] <= 8'h00;
    end else if (data_ok && state_r == LD_FETCH) begin
      bytes_r[recv_r[1:0]] <= opt_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opt_rd_out         <= 1'b0;
      opt_addr_out       <= `OPT_ADDR_WDOG;
      cpu_reset_hold_out <= 1'b1;
    end else begin
      opt_rd_out         <= issue_go;
      opt_addr_out       <= `OPT_ADDR_WDOG + opt_addr_t'(issue_r);
      // cpu stays held until the last byte has landed
      cpu_reset_hold_out <= (state_nxt != LD_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire opt_byte_t wd_b  = bytes_r[0];
  wire opt_byte_t vd_b  = bytes_r[1];
  wire opt_byte_t osc_b = bytes_r[2];
  wire loaded = (state_r == LD_DONE);
  wire [1:0] vd_mode = vd_b[`VD_MODE_HI:`VD_MODE_LO];
  wire [2:0] wd_psel = wd_b[`WD_PSEL_HI:`WD_PSEL_LO];

  // decoded fields are re-registered each cycle from the latched bytes

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdog_count_in_standby_out  <= 1'b0;
      wdog_period_sel_out        <= 3'd0;
      wdog_run_after_reset_out   <= 1'b0;
      wdog_open_period_out       <= 2'd0;
      wdog_interval_irq_en_out   <= 1'b0;
      vdet_coarse_code_out       <= 3'd0;
      reset_pin_function_sel_out <= 1'b0;
      vdet_fine_code_out         <= 2'd0;
      vdet_mode_out              <= 2'd0;
      vdet_int_rst_mode_out      <= 1'b0;
      vdet_rst_only_mode_out     <= 1'b0;
      flash_mode_out             <= 2'd0;
      fast_osc_freq_sel_out      <= 4'd0;
      debug_opt_out              <= 8'h00;
    end else begin
      wdog_count_in_standby_out  <= wd_b[`WD_STBY_BIT];
      wdog_period_sel_out        <= wd_psel;
      wdog_run_after_reset_out   <= wd_b[`WD_RUN_BIT];
      wdog_open_period_out       <= wd_b[`WD_WIN_HI:`WD_WIN_LO];
      wdog_interval_irq_en_out   <= wd_b[`WD_IRQ_BIT];
      vdet_coarse_code_out       <= vd_b[`VD_COARSE_HI:`VD_COARSE_LO];
      reset_pin_function_sel_out <= vd_b[`VD_PIN_BIT];
      vdet_fine_code_out         <= vd_b[`VD_FINE_HI:`VD_FINE_LO];
      vdet_mode_out              <= vd_mode;
      vdet_int_rst_mode_out      <= loaded && (vd_mode == `VD_MODE_INT_RST);
      vdet_rst_only_mode_out     <= loaded && (vd_mode == `VD_MODE_RST);
      flash_mode_out             <= osc_b[`OSC_FLASH_HI:`OSC_FLASH_LO];
      fast_osc_freq_sel_out      <= osc_b[`OSC_FREQ_HI:`OSC_FREQ_LO];
      debug_opt_out              <= bytes_r[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog timebase: counts half slow cycles, two per tick, so the 75%+1/2 irq fires on the tick at 75% plus one slow cycle
  wd_count_t  period;
  logic [17:0] half_cnt_r;
  logic        irq_done_r;
  assign period = period_of(wd_psel);
  wire [17:0] full_h   = {period, 1'b0};
  wire [17:0] irq_h    = three_half_of(period) + 18'd1;                 // 75% + half
  wire [1:0]  win      = wd_b[`WD_WIN_HI:`WD_WIN_LO];
  wire [17:0] win_h    = win_start_of(win, period);
  wire wd_active = loaded && wd_b[`WD_RUN_BIT];
  wire stall     = standby_in && !wd_b[`WD_STBY_BIT];
  // the tick is a one-cycle pulse per slow cycle; a held tick steps every cycle
  wire step      = wd_active && !stall && slow_osc_tick_in;
  wire [17:0] h_next = half_cnt_r + 18'd2;
  wire ovf       = step && (h_next >= full_h);
  wire irq_hit   = step && wd_b[`WD_IRQ_BIT] && !irq_done_r && (h_next >= irq_h);

  // a refresh outranks overflow in the count, but a kick on the last tick still pulses wdog_overflow_out from ovf
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      half_cnt_r <= 18'd0;
      irq_done_r <= 1'b0;
    end else begin
      if (wd_active && wdog_refresh_in) begin
        half_cnt_r <= 18'd0;
        irq_done_r <= 1'b0;
      end else if (ovf) begin
        half_cnt_r <= 18'd0;
        irq_done_r <= 1'b0;
      end else if (step) begin
        half_cnt_r <= h_next;
        if (irq_hit) irq_done_r <= 1'b1;
      end
    end
  end

  // event outputs are registered copies, one cycle behind the count
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdog_interval_irq_out <= 1'b0;
      wdog_overflow_out     <= 1'b0;
      wdog_window_open_out  <= 1'b0;
    end else begin
      wdog_interval_irq_out <= irq_hit;
      wdog_overflow_out     <= ovf;
      wdog_window_open_out  <= wd_active && (half_cnt_r >= win_h);
    end
  end
endmodule : option_byte_config_decode
`default_nettype wire
